/* core/dnvm_pkg.sv */
// shared constants and types for the data nonvolatile memory controller
package dnvm_pkg;

    // register offsets on the core register port
    localparam logic [7:0] DNVM_OFS_BUF    = 8'h08;
    localparam logic [7:0] DNVM_OFS_PTR    = 8'h09;
    localparam logic [7:0] DNVM_OFS_CTRL   = 8'h88;
    localparam logic [7:0] DNVM_OFS_UNLOCK = 8'h89;

    // control register field positions
    localparam int DNVM_BIT_RD     = 0;
    localparam int DNVM_BIT_WR     = 1;
    localparam int DNVM_BIT_PERMIT = 2;
    localparam int DNVM_BIT_ABORT  = 3;
    localparam int DNVM_BIT_DONE   = 4;

    // unlock keys
    localparam logic [7:0] DNVM_KEY_FIRST  = 8'h55;
    localparam logic [7:0] DNVM_KEY_SECOND = 8'hAA;

    // reset values
    localparam logic [7:0] DNVM_RST_BYTE = 8'h00;
    localparam logic       DNVM_RST_BIT  = 1'b0;

    // memory geometry
    localparam int DNVM_DEPTH  = 64;
    localparam int DNVM_AWIDTH = 6;

    // timing: figures in microseconds, counts derived from the clock rate
    localparam int DNVM_CLK_MHZ       = 20;
    localparam int DNVM_WRITE_TIME_US = 4000;
    localparam int DNVM_POWERUP_DELAY_TIMER_TIME_US  = 72000;
    localparam int DNVM_WRITE_CYC     = DNVM_WRITE_TIME_US * DNVM_CLK_MHZ;
    localparam int DNVM_POWERUP_DELAY_TIMER_CYC      = DNVM_POWERUP_DELAY_TIMER_TIME_US * DNVM_CLK_MHZ;

    // unlock sequence states
    typedef enum logic [1:0] {
        DNVM_IDLE  = 2'b00,
        DNVM_KEY1  = 2'b01,
        DNVM_ARMED = 2'b10
    } dnvm_unlock_t;

endpackage

/* core/dnvm_mem_if.sv */
// carrier between the controller and its byte array
`timescale 1ns/1ps
`default_nettype none
interface dnvm_mem_if;
    import dnvm_pkg::*;
    logic                   we;
    logic [DNVM_AWIDTH-1:0] waddr;
    logic [7:0]             wdata;
    logic                   re;
    logic [DNVM_AWIDTH-1:0] raddr;
    logic [7:0]             rdata;

    modport ctrl (output we, output waddr, output wdata,
                  output re, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata,
                  input re, input raddr, output rdata);
endinterface
`default_nettype wire

/* core/dnvm_mem.sv */
// byte array with registered read data
`timescale 1ns/1ps
`default_nettype none
module dnvm_mem (
    // clock
    input wire logic clk,
    // access port
    dnvm_mem_if.mem  m
);
    import dnvm_pkg::*;

    logic [7:0] cells [DNVM_DEPTH];

    // storage carries no reset, like the cell array it models
    always_ff @(posedge clk) begin
        if (m.we) begin
            cells[m.waddr] <= m.wdata;
        end
    end

    // read data held until the next read
    always_ff @(posedge clk) begin
        if (m.re) begin
            m.rdata <= cells[m.raddr];
        end
    end
endmodule
`default_nettype wire

/* core/dnvm_ctrl.sv */
// data nonvolatile memory write controller, core register side
// What this block and its software do
// RULE1 - unlock 55h then AAh, then set start
// RULE2 - no write without write permit set
// RULE3 - start bit stays clear without permit
// RULE4 - hardware never clears write permit itself
// RULE5 - clearing permit mid-write does not stop it
// RULE6 - completion clears start, sets done together
// RULE7 - done flag stays until software clears it; the block also clears it on a pin or watchdog reset
// RULE8 - power-up clears write permit
// RULE9 - power-up delay blocks all writes
// RULE10 - software masks interrupts during unlock
// RULE11 - software keeps permit clear when idle
// RULE12 - core access works under code protection
// RULE13 - lock fuse: 0 protects, 1 unprotected
// RULE14 - software verifies stressed writes by readback
// RULE15 - read trigger loads buffer next cycle
// RULE16 - unlock port reads back all zeros
// RULE17 - reset during write sets abort flag
// RULE18 - control upper three bits read zero
// RULE19 - unlock tracked by small state machine
// RULE20 - start and read bits are set-only
`timescale 1ns/1ps
`default_nettype none
module dnvm_ctrl #(
    parameter int WRITE_CYC = dnvm_pkg::DNVM_WRITE_CYC,
    parameter int POWERUP_DELAY_TIMER_CYC  = dnvm_pkg::DNVM_POWERUP_DELAY_TIMER_CYC
) (
    // clock and power-on reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // pin and watchdog resets, asynchronous sources
    input  wire logic       pin_reset_n,
    input  wire logic       wdt_reset,
    // configuration fuses
    input  wire logic       powerup_delay_timer_enable_n,
    input  wire logic       data_lock_fuse,
    // core register port
    input  wire logic [7:0] cpu_addr,
    input  wire logic [7:0] cpu_wdata,
    input  wire logic       cpu_we,
    input  wire logic       cpu_re,
    output logic      [7:0] cpu_rdata,
    // status
    output logic            store_done_flag,
    output logic            write_busy,
    output logic            data_protected
);
    import dnvm_pkg::*;

    localparam int WCW = $clog2(WRITE_CYC + 1);
    localparam int PCW = $clog2(POWERUP_DELAY_TIMER_CYC + 1);

    dnvm_mem_if mif ();

    logic [1:0]   prst_sync, wdt_sync, powerup_delay_timer_sync, lock_sync;
    logic         soft_rst;
    logic [PCW-1:0] powerup_delay_timer_cnt_reg;
    logic [WCW-1:0] wcnt_reg;
    dnvm_unlock_t unlock_reg;
    logic [7:0]   buf_reg, ptr_reg, wl_addr_reg, wl_data_reg;
    logic         rd_reg, wr_reg, store_permit, store_abort_flag;
    logic         done_reg;
    logic         wr_ctrl, wr_unlock, wr_buf, wr_ptr;
    logic         start_go, finish, rd_go;

    // two-stage synchronisers for pins and fuses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prst_sync <= 2'h3;
            wdt_sync  <= 2'h0;
            powerup_delay_timer_sync <= 2'h0;
            lock_sync <= 2'h0;
        end else begin
            prst_sync <= {prst_sync[0], pin_reset_n};
            wdt_sync  <= {wdt_sync[0], wdt_reset};
            powerup_delay_timer_sync <= {powerup_delay_timer_sync[0], powerup_delay_timer_enable_n};
            lock_sync <= {lock_sync[0], data_lock_fuse};
        end
    end

    assign soft_rst = !prst_sync[1] || wdt_sync[1];

    // register decode; protection never gates the core [RULE12]
    assign wr_ctrl   = cpu_we && !soft_rst && cpu_addr == DNVM_OFS_CTRL;
    assign wr_unlock = cpu_we && !soft_rst && cpu_addr == DNVM_OFS_UNLOCK;
    assign wr_buf    = cpu_we && !soft_rst && cpu_addr == DNVM_OFS_BUF;
    assign wr_ptr    = cpu_we && !soft_rst && cpu_addr == DNVM_OFS_PTR;

    // start needs key sequence, permit, idle cell and expired delay
    assign start_go = wr_ctrl && cpu_wdata[DNVM_BIT_WR] && !wr_reg
                   && unlock_reg == DNVM_ARMED          // [RULE1]
                   && store_permit                      // [RULE2] [RULE3]
                   && powerup_delay_timer_cnt_reg == '0;               // [RULE9]
    assign finish   = wr_reg && wcnt_reg == '0 && !soft_rst;
    // reads are refused while a write owns the array
    assign rd_go    = wr_ctrl && cpu_wdata[DNVM_BIT_RD] && !wr_reg;

    // power-up delay; a disabled timer is zeroed once its fuse is seen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            powerup_delay_timer_cnt_reg <= PCW'(POWERUP_DELAY_TIMER_CYC);
        end else if (powerup_delay_timer_sync[1]) begin
            powerup_delay_timer_cnt_reg <= '0;
        end else if (powerup_delay_timer_cnt_reg != '0) begin
            powerup_delay_timer_cnt_reg <= powerup_delay_timer_cnt_reg - PCW'(1);          // [RULE9]
        end
    end

    // unlock tracker: any write that does not advance it drops it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unlock_reg <= DNVM_IDLE;
        end else if (soft_rst) begin
            unlock_reg <= DNVM_IDLE;
        end else if (cpu_we) begin
            unlock_reg <= DNVM_IDLE;                          // [RULE19]
            if (wr_unlock && unlock_reg == DNVM_IDLE
                && cpu_wdata == DNVM_KEY_FIRST) begin
                unlock_reg <= DNVM_KEY1;                      // [RULE1]
            end else if (wr_unlock && unlock_reg == DNVM_KEY1
                         && cpu_wdata == DNVM_KEY_SECOND) begin
                unlock_reg <= DNVM_ARMED;                     // [RULE19]
            end
        end
    end

    // write permit: software only, cleared by power-on alone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            store_permit <= DNVM_RST_BIT;                     // [RULE8]
        end else if (wr_ctrl) begin
            store_permit <= cpu_wdata[DNVM_BIT_PERMIT];       // [RULE4]
        end
    end

    // write cycle timer; permit is not looked at once running
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg   <= DNVM_RST_BIT;
            wcnt_reg <= '0;
        end else if (soft_rst) begin
            wr_reg   <= DNVM_RST_BIT;
            wcnt_reg <= '0;
        end else if (start_go) begin
            wr_reg   <= 1'b1;
            wcnt_reg <= WCW'(WRITE_CYC - 1);
        end else if (finish) begin
            wr_reg   <= 1'b0;                                 // [RULE6]
        end else if (wr_reg) begin
            wcnt_reg <= wcnt_reg - WCW'(1);                   // [RULE5]
        end
    end

    // done flag: completion wins over a software clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_reg <= DNVM_RST_BIT;
        end else if (soft_rst) begin
            done_reg <= DNVM_RST_BIT;
        end else if (finish) begin
            done_reg <= 1'b1;                                 // [RULE6]
        end else if (wr_ctrl) begin
            done_reg <= cpu_wdata[DNVM_BIT_DONE];             // [RULE7]
        end
    end

    // abort flag: survives the pin and watchdog resets it reports
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            store_abort_flag <= DNVM_RST_BIT;
        end else if (soft_rst && wr_reg) begin
            store_abort_flag <= 1'b1;                         // [RULE17]
        end else if (wr_ctrl) begin
            store_abort_flag <= cpu_wdata[DNVM_BIT_ABORT];
        end
    end

    // read trigger is set-only and clears one cycle later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_reg <= DNVM_RST_BIT;
        end else begin
            rd_reg <= rd_go && !rd_reg;                       // [RULE20]
        end
    end

    // buffer and pointer keep their value over soft resets
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_reg <= DNVM_RST_BYTE;
            ptr_reg <= DNVM_RST_BYTE;
        end else begin
            if (wr_ptr) begin
                ptr_reg <= cpu_wdata;
            end
            if (rd_reg) begin
                buf_reg <= mif.rdata;                         // [RULE15]
            end else if (wr_buf) begin
                buf_reg <= cpu_wdata;
            end
        end
    end

    // latch target at start so later bus writes cannot skew it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wl_addr_reg <= DNVM_RST_BYTE;
            wl_data_reg <= DNVM_RST_BYTE;
        end else if (start_go) begin
            wl_addr_reg <= ptr_reg;
            wl_data_reg <= buf_reg;
        end
    end

    // array port; a pointer above the 64 bytes drops the write, reads use the low six bits
    assign mif.we    = finish && wl_addr_reg[7:DNVM_AWIDTH] == '0;
    assign mif.waddr = wl_addr_reg[DNVM_AWIDTH-1:0];
    assign mif.wdata = wl_data_reg;
    assign mif.re    = rd_go;
    assign mif.raddr = ptr_reg[DNVM_AWIDTH-1:0];

    dnvm_mem u_mem (
        .clk (clk),
        .m   (mif.mem)
    );

    // registered read mux; unmapped addresses answer zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rdata <= DNVM_RST_BYTE;
        end else if (cpu_re) begin
            if (cpu_addr == DNVM_OFS_BUF) begin
                cpu_rdata <= buf_reg;
            end else if (cpu_addr == DNVM_OFS_PTR) begin
                cpu_rdata <= ptr_reg;
            end else if (cpu_addr == DNVM_OFS_CTRL) begin
                cpu_rdata <= {3'h0, done_reg, store_abort_flag,
                              store_permit, wr_reg, rd_reg};  // [RULE18]
            end else begin
                cpu_rdata <= DNVM_RST_BYTE;                   // [RULE16]
            end
        end
    end

    // status outputs, all registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            store_done_flag <= DNVM_RST_BIT;
            write_busy      <= DNVM_RST_BIT;
            data_protected  <= DNVM_RST_BIT;
        end else begin
            store_done_flag <= done_reg;
            write_busy      <= wr_reg;
            data_protected  <= !lock_sync[1];                 // [RULE13]
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_key_seq;
        $rose(wr_reg) |-> $past(unlock_reg) == DNVM_ARMED;
    endproperty
    a_key_seq: assert property (p_key_seq) else $error("start w/o keys"); // [RULE1]

    property p_need_permit;
        $rose(wr_reg) |-> $past(store_permit);
    endproperty
    a_need_permit: assert property (p_need_permit) else $error("no permit"); // [RULE2]

    property p_wr_blocked;
        wr_ctrl && cpu_wdata[DNVM_BIT_WR] && !store_permit && !wr_reg
            |=> !wr_reg;
    endproperty
    a_wr_blocked: assert property (p_wr_blocked) else $error("wr set"); // [RULE3]

    property p_permit_sw;
        $changed(store_permit) |-> $past(wr_ctrl);
    endproperty
    a_permit_sw: assert property (p_permit_sw) else $error("permit hw"); // [RULE4]

    property p_runs_on;
        wr_reg && wcnt_reg != '0 && !soft_rst |=> wr_reg;
    endproperty
    a_runs_on: assert property (p_runs_on) else $error("write cut"); // [RULE5]

    property p_done_pair;
        $fell(wr_reg) && !$past(soft_rst) |-> done_reg && mif.we == 1'b0;
    endproperty
    a_done_pair: assert property (p_done_pair) else $error("no done"); // [RULE6]

    property p_done_hold;
        done_reg && !soft_rst && !(wr_ctrl && !cpu_wdata[DNVM_BIT_DONE])
            |=> done_reg;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done lost"); // [RULE7]

    property p_powerup_delay_timer_block;
        powerup_delay_timer_cnt_reg != '0 |=> !$rose(wr_reg);
    endproperty
    a_powerup_delay_timer_block: assert property (p_powerup_delay_timer_block) else $error("early wr"); // [RULE9]

    property p_read_load;
        rd_go |=> ##1 buf_reg == $past(mif.rdata) && !rd_reg;
    endproperty
    a_read_load: assert property (p_read_load) else $error("bad read"); // [RULE15]

    property p_unlock_zero;
        cpu_re && cpu_addr == DNVM_OFS_UNLOCK |=> cpu_rdata == 8'h00;
    endproperty
    a_unlock_zero: assert property (p_unlock_zero) else $error("nz"); // [RULE16]

    property p_abort;
        soft_rst && wr_reg |=> store_abort_flag && $stable(buf_reg)
                               && $stable(ptr_reg) && !wr_reg;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort"); // [RULE17]

    property p_ctrl_upper;
        cpu_re && cpu_addr == DNVM_OFS_CTRL |=> cpu_rdata[7:5] == 3'h0;
    endproperty
    a_ctrl_upper: assert property (p_ctrl_upper) else $error("upper"); // [RULE18]

    property p_bad_key;
        wr_unlock && cpu_wdata != DNVM_KEY_FIRST && unlock_reg == DNVM_IDLE
            |=> unlock_reg == DNVM_IDLE;
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("bad key"); // [RULE19]

    c_write_done: cover property ($fell(wr_reg) && done_reg);
    c_read: cover property (rd_go ##2 cpu_re);
    c_abort: cover property (soft_rst && wr_reg);
    c_armed: cover property (unlock_reg == DNVM_ARMED);
endmodule
`default_nettype wire

/* tb/dnvm_cpu_model.sv */
// processor core model issuing byte accesses to the controller registers
`timescale 1ns/1ps
`default_nettype none
module dnvm_cpu_model (
    // clock
    input  wire logic       clk,
    // register port
    output logic      [7:0] cpu_addr,
    output logic      [7:0] cpu_wdata,
    output logic            cpu_we,
    output logic            cpu_re,
    input  wire logic [7:0] cpu_rdata
);
    import dnvm_pkg::*;

    // idle bus at time zero
    initial begin
        cpu_addr  = 8'h00;
        cpu_wdata = 8'h00;
        cpu_we    = 1'b0;
        cpu_re    = 1'b0;
    end

    // one write strobe held over the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cpu_addr  <= a;
        cpu_wdata <= d;
        cpu_we    <= 1'b1;
        @(posedge clk);
        cpu_we    <= 1'b0;
        cpu_wdata <= ~d; // released data never shows the old byte
    endtask

    // read strobe; data is registered, so sample a half cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        cpu_addr <= a;
        cpu_re   <= 1'b1;
        @(posedge clk);
        cpu_re <= 1'b0;
        @(negedge clk);
        d = cpu_rdata;
    endtask

    // byte store; one idle cycle between writes but no other access, as with interrupts masked
    task automatic store(input logic [7:0] a, input logic [7:0] d,
                         input logic [7:0] c);
        wr(DNVM_OFS_PTR, a);
        wr(DNVM_OFS_BUF, d);
        wr(DNVM_OFS_CTRL, c); // permit raised only for the update
        wr(DNVM_OFS_UNLOCK, DNVM_KEY_FIRST);
        wr(DNVM_OFS_UNLOCK, DNVM_KEY_SECOND);
        wr(DNVM_OFS_CTRL, c | 8'h02);
    endtask

    // read trigger then buffer read, drops permit again
    task automatic fetch(input logic [7:0] a, output logic [7:0] d);
        wr(DNVM_OFS_PTR, a);
        wr(DNVM_OFS_CTRL, 8'h01);
        rd(DNVM_OFS_BUF, d);
    endtask
endmodule
`default_nettype wire

/* tb/dnvm_ctrl_tb.sv */
// self-checking bench for the data nonvolatile memory controller
`timescale 1ns/1ps
`default_nettype none
module dnvm_ctrl_tb;
    import dnvm_pkg::*;
    // short counts keep the run brief
    localparam int WCYC = 20;
    localparam int PCYC = 30;
    logic       clk, rst_n, pin_reset_n, wdt_reset;
    logic       powerup_delay_timer_enable_n, data_lock_fuse, cpu_we, cpu_re;
    logic       store_done_flag, write_busy, data_protected;
    logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, rv, seed, a, d;
    logic [7:0] exp_mem [64];
    int         n_errors, cmp_count;

    dnvm_ctrl #(.WRITE_CYC(WCYC), .POWERUP_DELAY_TIMER_CYC(PCYC)) i_dnvm_ctrl (
        .clk(clk), .rst_n(rst_n), .pin_reset_n(pin_reset_n),
        .wdt_reset(wdt_reset), .powerup_delay_timer_enable_n(powerup_delay_timer_enable_n),
        .data_lock_fuse(data_lock_fuse), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_we(cpu_we), .cpu_re(cpu_re),
        .cpu_rdata(cpu_rdata), .store_done_flag(store_done_flag),
        .write_busy(write_busy), .data_protected(data_protected));
    dnvm_cpu_model i_dnvm_cpu_model (
        .clk(clk), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_we(cpu_we), .cpu_re(cpu_re), .cpu_rdata(cpu_rdata));

    // 20 MHz core clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                        input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h want %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %b", $time, what, got);
        end
    endtask

    task automatic print_verdict;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // bench pseudo-random source
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // bounded wait on the completion flag, sampled mid-cycle
    task automatic wait_done;
        for (int k = 0; k < 4 * WCYC && store_done_flag !== 1'b1; k++)
            @(negedge clk);
        if (store_done_flag !== 1'b1) begin
            n_errors++;
            $display("unexpected at %0t: write never completed", $time);
            print_verdict();
        end
        chk1(write_busy, 1'b0, "start with done");
    endtask

    initial begin
        rst_n          = 1'b0;
        pin_reset_n    = 1'b1;
        wdt_reset      = 1'b0;
        powerup_delay_timer_enable_n  = 1'b0;
        data_lock_fuse = 1'b1;
        n_errors       = 0;
        cmp_count      = 0;
        seed           = 8'h1E;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // reset state and a store tried while the delay still runs
        i_dnvm_cpu_model.rd(DNVM_OFS_CTRL, rv);
        chk8(rv, 8'h00, "ctrl reset");
        i_dnvm_cpu_model.rd(DNVM_OFS_UNLOCK, rv);
        chk8(rv, 8'h00, "unlock read");
        i_dnvm_cpu_model.store(8'h05, 8'h3C, 8'h04);
        i_dnvm_cpu_model.rd(DNVM_OFS_CTRL, rv);
        chk8(rv, 8'h04, "start in delay");
        repeat (PCYC) @(posedge clk);
        // full sequence without permit must not start
        i_dnvm_cpu_model.store(8'h05, 8'h3C, 8'h00);
        i_dnvm_cpu_model.rd(DNVM_OFS_CTRL, rv);
        chk8(rv, 8'h00, "start no permit");
        // stray write inside the sequence, then keys swapped
        for (int j = 0; j < 2; j++) begin
            i_dnvm_cpu_model.wr(DNVM_OFS_CTRL, 8'h04);
            i_dnvm_cpu_model.wr(DNVM_OFS_UNLOCK, j ? 8'hAA : 8'h55);
            if (j == 0) i_dnvm_cpu_model.wr(DNVM_OFS_BUF, 8'h3C);
            i_dnvm_cpu_model.wr(DNVM_OFS_UNLOCK, j ? 8'h55 : 8'hAA);
            i_dnvm_cpu_model.wr(DNVM_OFS_CTRL, 8'h06);
            i_dnvm_cpu_model.rd(DNVM_OFS_CTRL, rv);
            chk8(rv, 8'h04, "broken unlock");
        end
        // random stores, top location first, fuse toggled each pass
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            a    = {2'b00, seed[5:0]};
            seed = lfsr(seed);
            d    = seed;
            if (i == 0) begin
                a = 8'h3F;
                d = 8'hFF;
            end
            data_lock_fuse <= i[0];
            i_dnvm_cpu_model.store(a, d, 8'h04);
            if (i[0]) i_dnvm_cpu_model.wr(DNVM_OFS_CTRL, 8'h00);
            repeat (2) @(negedge clk);
            chk1(write_busy, 1'b1, "busy mid write");
            wait_done();
            exp_mem[a[5:0]] = d;
            repeat (8) @(negedge clk);
            chk1(store_done_flag, 1'b1, "done held");
            i_dnvm_cpu_model.rd(DNVM_OFS_CTRL, rv);
            chk8(rv, i[0] ? 8'h10 : 8'h14, "ctrl after");
            i_dnvm_cpu_model.fetch(a, rv);
            chk8(rv, d, "readback");
            chk1(store_done_flag, 1'b0, "done cleared");
            chk1(data_protected, ~i[0], "lock fuse");
        end
        // pin reset, then watchdog reset, in mid-write
        for (int j = 0; j < 2; j++) begin
            i_dnvm_cpu_model.store(8'h3F, 8'h5A, 8'h04);
            if (j == 0) pin_reset_n <= 1'b0;
            else wdt_reset <= 1'b1;
            repeat (4) @(posedge clk);
            pin_reset_n <= 1'b1;
            wdt_reset   <= 1'b0;
            repeat (WCYC) @(posedge clk);
            i_dnvm_cpu_model.rd(DNVM_OFS_CTRL, rv);
            chk8(rv, 8'h0C, "abort ctrl");
            i_dnvm_cpu_model.rd(DNVM_OFS_PTR, rv);
            chk8(rv, 8'h3F, "ptr kept");
            i_dnvm_cpu_model.rd(DNVM_OFS_BUF, rv);
            chk8(rv, 8'h5A, "buf kept");
            i_dnvm_cpu_model.fetch(8'h3F, rv);
            chk8(rv, exp_mem[63], "aborted byte");
        end
        // pointer above the 64 bytes: cycle completes, array untouched
        i_dnvm_cpu_model.store(8'hFF, 8'h11, 8'h04);
        wait_done();
        i_dnvm_cpu_model.fetch(8'h3F, rv);
        chk8(rv, exp_mem[63], "high ptr store");
        // upper control bits are not stored
        i_dnvm_cpu_model.wr(DNVM_OFS_CTRL, 8'hE4);
        i_dnvm_cpu_model.rd(DNVM_OFS_CTRL, rv);
        chk8(rv, 8'h04, "ctrl upper");
        print_verdict();
    end
endmodule
`default_nettype wire
